/* hdl/acs_defs.svh */
// Constants of the converter sequencer: offsets, bit positions, counts
// Assumes byte-wide register port and one system clock
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_OFS_RES_LO 8'h78
`define ACS_OFS_RES_HI 8'h79
`define ACS_OFS_TRIG 8'h7B
`define ACS_OFS_CTRL 8'h7A
`define ACS_OFS_MUX 8'h7C
`define ACS_RST_BYTE 8'h00
`define ACS_B_ON 7
`define ACS_B_GO 6
`define ACS_B_AUTO 5
`define ACS_B_DONE 4
`define ACS_B_IRQEN 3
`define ACS_B_JUST 5
`define ACS_B_FREE 0
`define ACS_F_DIV 2:0
`define ACS_F_REF 7:6
`define ACS_F_CHAN 4:0
`define ACS_CYC_FIRST 5'h19
`define ACS_CYC_NORMAL 5'h0D
`define ACS_CH_BANDGAP 5'h1E
`define ACS_CH_GROUND 5'h1F
`define ACS_CH_DIFF_LO 5'h10
`define ACS_CH_DIFF_HI 5'h1D
`define ACS_POS_MAX 10'h1FF
`define ACS_NEG_MIN 10'h200
`define ACS_SE_MAX 10'h3FF
`endif

/* hdl/acs_pkg.sv */
// Types of the converter sequencer
// Shared by the register and sequencing logic
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_WAIT_TICK = 2'b01,
        ACS_CONVERT = 2'b10,
        ACS_WAIT_CORE = 2'b11
    } acs_state_t;
endpackage

/* hdl/acs_top.sv */
// Converter sequencer with control, input select and result registers
// Assumes a converter core on clk answering start with done and a code
// Function
// - single-ended results are unsigned 10-bit, 0x000 ground to 0x3FF just below reference.
// - differential results are two's complement, 512 steps per reference, clamped to 511 and -512.
// - a finished result is in the result registers when the done flag rises, unless results are held; then it is lost and the flag still rises.
// - reference field bits 7:6 select external pin, supply or internal 1.1 V, 10 reserved.
// - reference and channel changes during a conversion apply only after it completes.
// - bit 5 selects left or right justification and acts on reads at once.
// - the channel field maps to single-ended, input minus 1, input minus 2, bandgap, ground.
// - the enable bit powers the converter; clearing it aborts a running conversion.
// - writing the go bit starts a single conversion or the first of a free run.
// - the first conversion after enabling takes 25 converter cycles, later ones 13.
// - the go bit reads one while converting, clears on completion except in free run, ignores written zero.
// - the done flag sets on completion and clears on interrupt service or written one.
// - the prescaler field divides the clock by 2,2,4,8,16,32,64,128.
// - with auto trigger on and free run off, a rising trigger edge while idle starts a conversion.
// - after the low result byte is read, results are held until the high byte is read.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "acs_defs.svh"

module acs_top
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic irq_ack,
    input wire logic trigger_pin,
    input wire logic core_done,
    input wire logic [10:0] core_code,
    output logic core_power,
    output logic core_start,
    output logic core_init,
    output logic [1:0] core_ref_sel,
    output logic [4:0] core_channel,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic is_diff(input logic [4:0] ch);
        is_diff = (ch >= `ACS_CH_DIFF_LO) && (ch <= `ACS_CH_DIFF_HI);
    endfunction

    function automatic logic [6:0] div_top(input logic [2:0] sel);
        logic [7:0] d;
        d = (sel == 3'h0) ? 8'h02 : (8'h01 << sel);
        div_top = 7'(d - 8'h01);
    endfunction

    function automatic logic [9:0] clamp_code(input logic diff, input logic [10:0] c);
        if (diff) begin
            if (!c[10] && c[9]) begin
                clamp_code = `ACS_POS_MAX;
            end else if (c[10] && !c[9]) begin
                clamp_code = `ACS_NEG_MIN;
            end else begin
                clamp_code = c[9:0];
            end
        end else begin
            clamp_code = c[10] ? `ACS_SE_MAX : c[9:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    acs_state_t state_q;
    logic on_q, go_q, auto_q, done_q, irqen_q, free_q, just_q, first_q, lock_q;
    logic [2:0] div_sel_q;
    logic [1:0] ref_q;
    logic [4:0] chan_q;
    logic [9:0] result_q;
    logic [6:0] pre_q;
    logic [4:0] cyc_q;
    logic tick;
    logic wr_ctrl, wr_mux, wr_trig, conv_end, trig_rise, start_req;
    logic [2:0] trig_sync_q;
    logic trig_lvl_q, trig_prev_q;

    assign wr_ctrl = reg_wr && (reg_addr == `ACS_OFS_CTRL);
    assign wr_mux = reg_wr && (reg_addr == `ACS_OFS_MUX);
    assign wr_trig = reg_wr && (reg_addr == `ACS_OFS_TRIG);
    assign tick = on_q && (pre_q == div_top(div_sel_q));
    assign conv_end = (state_q == ACS_WAIT_CORE) && core_done;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            on_q <= 1'b0;
            auto_q <= 1'b0;
            irqen_q <= 1'b0;
            div_sel_q <= 3'h0;
            free_q <= 1'b0;
        end else if (wr_ctrl) begin
            on_q <= reg_wdata[`ACS_B_ON];
            auto_q <= reg_wdata[`ACS_B_AUTO];
            irqen_q <= reg_wdata[`ACS_B_IRQEN];
            div_sel_q <= reg_wdata[`ACS_F_DIV];
        end else if (wr_trig) begin
            free_q <= reg_wdata[`ACS_B_FREE];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_q <= 2'h0;
            just_q <= 1'b0;
            chan_q <= 5'h00;
        end else if (wr_mux) begin
            ref_q <= reg_wdata[`ACS_F_REF];
            just_q <= reg_wdata[`ACS_B_JUST];
            chan_q <= reg_wdata[`ACS_F_CHAN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter clock prescaler

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_q <= 7'h00;
        end else if (!on_q || tick) begin
            pre_q <= 7'h00;
        end else begin
            pre_q <= pre_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger pin filter and edge

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_sync_q <= 3'h0;
            trig_lvl_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            trig_sync_q <= {trig_sync_q[1:0], trigger_pin};
            if (trig_sync_q[1] == trig_sync_q[2]) begin
                trig_lvl_q <= trig_sync_q[2];
            end
            trig_prev_q <= trig_lvl_q;
        end
    end

    assign trig_rise = trig_lvl_q && !trig_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Start requests and the go bit

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            go_q <= 1'b0;
        end else if (wr_ctrl && !reg_wdata[`ACS_B_ON]) begin
            go_q <= 1'b0;
        end else if (wr_ctrl && reg_wdata[`ACS_B_GO]) begin
            go_q <= 1'b1;
        end else if (on_q && auto_q && !free_q && trig_rise && state_q == ACS_IDLE) begin
            go_q <= 1'b1;
        end else if (conv_end && auto_q && free_q) begin
            go_q <= 1'b1;
        end else if (conv_end) begin
            go_q <= 1'b0;
        end
    end

    assign start_req = go_q && on_q && (state_q == ACS_IDLE);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_q <= 1'b0;
        end else if (wr_ctrl && reg_wdata[`ACS_B_ON] && !on_q) begin
            first_q <= 1'b1;
        end else if (state_q == ACS_WAIT_TICK && tick) begin
            first_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequence

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ACS_IDLE;
            cyc_q <= 5'h00;
        end else if (!on_q || (wr_ctrl && !reg_wdata[`ACS_B_ON])) begin
            state_q <= ACS_IDLE;
            cyc_q <= 5'h00;
        end else begin
            case (state_q)
                ACS_IDLE: begin
                    if (start_req) begin
                        state_q <= ACS_WAIT_TICK;
                    end
                end
                ACS_WAIT_TICK: begin
                    if (tick) begin
                        state_q <= ACS_CONVERT;
                        cyc_q <= first_q ? `ACS_CYC_FIRST : `ACS_CYC_NORMAL;
                    end
                end
                ACS_CONVERT: begin
                    if (tick && cyc_q == 5'h01) begin
                        state_q <= ACS_WAIT_CORE;
                    end else if (tick) begin
                        cyc_q <= cyc_q - 5'h01;
                    end
                end
                ACS_WAIT_CORE: begin
                    if (core_done) begin
                        state_q <= go_q && auto_q && free_q ? ACS_WAIT_TICK : ACS_IDLE;
                    end
                end
                default: begin
                    state_q <= ACS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core interface

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            core_power <= 1'b0;
            core_start <= 1'b0;
            core_init <= 1'b0;
            core_ref_sel <= 2'h0;
            core_channel <= 5'h00;
        end else begin
            core_power <= on_q;
            core_start <= (state_q == ACS_WAIT_TICK) && tick;
            if (state_q == ACS_WAIT_TICK && tick) begin
                core_init <= first_q;
            end
            if (state_q == ACS_IDLE || conv_end) begin
                core_ref_sel <= ref_q;
                core_channel <= chan_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result capture and read lock

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result_q <= 10'h000;
        end else if (conv_end && !lock_q) begin
            if (core_channel == `ACS_CH_GROUND) begin
                result_q <= 10'h000;
            end else begin
                result_q <= clamp_code(is_diff(core_channel), core_code);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_q <= 1'b0;
        end else if (reg_rd && reg_addr == `ACS_OFS_RES_LO) begin
            lock_q <= 1'b1;
        end else if (reg_rd && reg_addr == `ACS_OFS_RES_HI) begin
            lock_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Done flag and interrupt

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done_q <= 1'b0;
        end else if (conv_end) begin
            done_q <= 1'b1;
        end else if (irq_ack || (wr_ctrl && reg_wdata[`ACS_B_DONE])) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= done_q && irqen_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= `ACS_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `ACS_OFS_CTRL: begin
                    reg_rdata <= {on_q, go_q, auto_q, done_q, irqen_q, div_sel_q};
                end
                `ACS_OFS_MUX: begin
                    reg_rdata <= {ref_q, just_q, chan_q};
                end
                `ACS_OFS_TRIG: begin
                    reg_rdata <= {7'h00, free_q};
                end
                `ACS_OFS_RES_LO: begin
                    reg_rdata <= just_q ? {result_q[1:0], 6'h00} : result_q[7:0];
                end
                `ACS_OFS_RES_HI: begin
                    reg_rdata <= just_q ? result_q[9:2] : {6'h00, result_q[9:8]};
                end
                default: begin
                    reg_rdata <= `ACS_RST_BYTE;
                end
            endcase
        end else begin
            reg_rdata <= `ACS_RST_BYTE;
        end
    end

endmodule // acs_top

/* bench/acs_core_model.sv */
// Converter core model: answers each start with done and a code
// Assumes start pulses on clk; code and answer delay set by the bench
`timescale 1ns/1ps
module acs_core_model (
    input wire logic clk,
    input wire logic core_power,
    input wire logic core_start,
    input wire logic [10:0] code,
    input wire logic [11:0] delay,
    output logic core_done,
    output logic [10:0] core_code
);
    logic [11:0] cnt_q = 12'h000;
    initial core_done = 1'b0;
    initial core_code = 11'h2AA;
    always @(posedge clk) begin
        if (!core_power || core_start) begin
            cnt_q <= delay;
            core_done <= 1'b0;
            core_code <= ~core_code;
        end else if (cnt_q != 12'h000) begin
            cnt_q <= cnt_q - 12'h001;
            core_code <= ~core_code;
        end else begin
            core_done <= 1'b1;
            core_code <= code;
        end
    end
endmodule // acs_core_model

/* bench/acs_monitor.sv */
// Port checker of the converter sequencer
// Assumes one clock and an async active-low reset
`timescale 1ns/1ps
module acs_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic core_done,
    input wire logic core_power,
    input wire logic core_start,
    input wire logic core_init,
    input wire logic [1:0] core_ref_sel,
    input wire logic [4:0] core_channel,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic ctl_wr;
    assign ctl_wr = reg_wr && reg_addr == 8'h7A;
    a_start_one_cycle: assert property (core_start |=> !core_start)
        else $error("start pulse too long");
    a_power_on: assert property (ctl_wr && reg_wdata[7] |-> ##2 core_power)
        else $error("power not on");
    a_power_off: assert property (ctl_wr && !reg_wdata[7] |-> ##2 !core_power)
        else $error("power not off");
    a_irq_needs_en: assert property (ctl_wr && !reg_wdata[3] |-> ##2 !irq)
        else $error("irq while disabled");
    a_go_readback: assert property (core_start ##1 (reg_rd && reg_addr == 8'h7A)
        |=> reg_rdata[6]) else $error("go bit low while busy");
    a_sel_frozen: assert property (core_start
        |=> ($stable(core_ref_sel) && $stable(core_channel)) [*8]) else $error("select moved");
    a_init_steady: assert property (core_start ##1 1'b1 |=> $stable(core_init) [*8])
        else $error("init changed");
    a_irq_cause: assert property ($rose(irq) |-> $past(core_done, 2) || $past(reg_wr, 2))
        else $error("irq without cause");
endmodule // acs_monitor
bind acs_top acs_monitor i_mon (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_done(core_done), .core_power(core_power), .core_start(core_start),
    .core_init(core_init), .core_ref_sel(core_ref_sel), .core_channel(core_channel),
    .irq(irq));

/* bench/tb_top.sv */
// Testbench of the converter sequencer
// Assumes the core model on the far side and the byte register port
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, irq_ack = 1'b0, trigger_pin = 1'b0;
    logic core_done, core_power, core_start, core_init, irq;
    logic [10:0] core_code, code = 11'h000;
    logic [11:0] delay = 12'h003;
    logic [1:0] core_ref_sel;
    logic [4:0] core_channel;
    int fail_count = 0, checks = 0, n;
    always #25 clk = ~clk;
    acs_top i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
        .trigger_pin(trigger_pin), .core_done(core_done), .core_code(core_code),
        .core_power(core_power), .core_start(core_start), .core_init(core_init),
        .core_ref_sel(core_ref_sel), .core_channel(core_channel), .irq(irq));
    acs_core_model i_core (.clk(clk), .core_power(core_power), .core_start(core_start),
        .code(code), .delay(delay), .core_done(core_done), .core_code(core_code));
    ////////////////////////////////////////////////////////////////////////////////
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, exp);
        @(posedge clk);
    endtask
    task wirq;
        while (irq !== 1'b1 && n < 4000) begin
            @(posedge clk);
            #1 n++;
        end
        cmp({7'h00, irq}, 8'h01);
        @(posedge clk);
    endtask
    task ack;
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task conv(input logic [7:0] m, input logic [7:0] c, input logic [10:0] k,
        input logic [9:0] e, input int lo, input int hi, input logic [11:0] d,
        input logic f);
        code <= k;
        delay <= d;
        wr(8'h7C, m);
        wr(8'h7A, c);
        n = 0;
        while (core_start !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
        cmp({7'h00, core_start}, 8'h01);
        cmp({core_ref_sel, 1'b0, core_channel}, m & 8'hDF);
        cmp({7'h00, core_init}, {7'h00, f});
        @(posedge clk);
        rd(8'h7A, c);
        wr(8'h7C, m ^ 8'h40);
        n = 5;
        wirq;
        cmp_rng(n, lo, hi);
        rd(8'h78, m[5] ? {e[1:0], 6'h00} : e[7:0]);
        rd(8'h79, m[5] ? e[9:2] : {6'h00, e[9:8]});
        rd(8'h7A, (c & 8'hBF) | 8'h10);
        ack;
        rd(8'h7A, c & 8'hBF);
    endtask
    task stop_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(60000 * 50);
        fail_count++;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(8'h7A, 8'h00);
        rd(8'h7C, 8'h00);
        rd(8'h7D, 8'h00);
        conv(8'hFB, 8'hC8, 11'h7A3, 10'h3A3, 48, 56, 12'h003, 1'b1);
        wr(8'h7C, 8'hDB);
        rd(8'h78, 8'hA3);
        rd(8'h79, 8'h03);
        conv(8'h40, 8'hC9, 11'h3FF, 10'h3FF, 120, 140, 12'h078, 1'b0);
        conv(8'h5F, 8'hCA, 11'h155, 10'h000, 48, 60, 12'h003, 1'b0);
        conv(8'h50, 8'hCB, 11'h258, 10'h1FF, 96, 116, 12'h003, 1'b0);
        conv(8'h58, 8'hCF, 11'h5A8, 10'h200, 1536, 1796, 12'h003, 1'b0);
        conv(8'hDE, 8'hCD, 11'h0AB, 10'h0AB, 384, 452, 12'h003, 1'b0);
        wr(8'h7A, 8'hC8);
        repeat (20) @(posedge clk);
        wr(8'h7A, 8'h00);
        repeat (80) @(posedge clk);
        rd(8'h7A, 8'h00);
        conv(8'h40, 8'hC8, 11'h123, 10'h123, 48, 56, 12'h003, 1'b1);
        wr(8'h7B, 8'h00);
        wr(8'h7A, 8'hAA);
        trigger_pin <= 1'b1;
        n = 0;
        wirq;
        cmp_rng(n, 40, 100);
        rd(8'h7A, 8'hBA);
        wr(8'h7A, 8'hA2);
        rd(8'h7A, 8'hB2);
        cmp({7'h00, irq}, 8'h00);
        wr(8'h7A, 8'hBA);
        rd(8'h7A, 8'hAA);
        wr(8'h7B, 8'h01);
        wr(8'h7A, 8'hEA);
        n = 0;
        wirq;
        ack;
        n = 0;
        wirq;
        cmp_rng(n, 30, 100);
        wr(8'h7A, 8'h00);
        stop_test;
    end
endmodule // tb_top
